/* File: logic/ddc_defs.svh */
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH
`define DDC_CTRL 8'h00
`define DDC_GEOM 8'h04
`define DDC_ASZ 8'h08
`define DDC_LIM 8'h0c
`define DDC_WGT 8'h10
`define DDC_STAT 8'h14
`define DDC_ACTV 8'h18
`define DDC_CTRL_RST 32'h0000_0000
`define DDC_GEOM_RST 32'h0000_0000
`define DDC_LIM_RST 32'hffff_ffff
`define DDC_WGT_RST 32'h0101_0101
`define DDC_F_MODE 1:0
`define DDC_F_THR_RD 2
`define DDC_F_THR_WR 3
`define DDC_F_THERM 4
`define DDC_F_LIM 5
`define DDC_F_DENS 1:0
`define DDC_F_PAGE 4:3
`define DDC_F_RANKS 6:5
`define DDC_F_PRES 11:8
`define DDC_F_FAST 15:12
`define DDC_W_ACT 7:0
`define DDC_W_RD 15:8
`define DDC_W_WR 23:16
`define DDC_W_PRE 31:24
`define DDC_D1G 2'h2
`define DDC_BAD 2'h3
`define DDC_OKAY 2'h0
`define DDC_SLVERR 2'h2
`define DDC_DW 64
`define DDC_BL 4'h8
`define DDC_BEAT_W 3
`define DDC_COL_MIN 9
`define DDC_BANKS 8
`define DDC_ILV_BIT 6
`define DDC_TREFI_NS 7800
`define DDC_CLK_MHZ 50
`define DDC_REF_CYC ((`DDC_TREFI_NS * `DDC_CLK_MHZ) / 1000)
`define DDC_REF_POST 4'h8
`define DDC_WIN_CYC 1024
`endif

/* File: logic/ddc_pkg.sv */
`default_nettype none
`include "ddc_defs.svh"
package ddc_pkg;
	typedef enum logic [1:0] {
		DDC_SINGLE = 2'h0,
		DDC_ASYM = 2'h1,
		DDC_ILV = 2'h2
	} ddc_mode_t;
	typedef enum logic [2:0] {DDC_NOP, DDC_ACT, DDC_RD, DDC_WR, DDC_PRE, DDC_REF} ddc_op_t;
	typedef enum logic [2:0] {S_IDLE, S_PRE, S_ACT, S_RW, S_RFP, S_RFR} ddc_st_t;
	typedef struct packed {
		logic [31:0] addr;
		logic wr;
		logic [`DDC_DW-1:0] wdata;
		logic [7:0] be;
	} ddc_req_t;
	typedef struct packed {
		logic ch;
		logic [1:0] rank;
		logic [2:0] bank;
		logic [15:0] row;
		logic [10:0] col;
		logic [2:0] beat;
	} ddc_loc_t;
	typedef struct packed {
		ddc_op_t op;
		logic [1:0] rank;
		logic [2:0] bank;
		logic [15:0] row;
		logic [10:0] col;
		logic all;
		logic [3:0] blen;
		logic [2:0] beat;
		logic [`DDC_DW-1:0] wdata;
		logic [`DDC_DW-1:0] byte_write_mask;
	} ddc_cmd_t;
endpackage : ddc_pkg
`default_nettype wire

/* File: logic/ddc_top.sv */
// What this block does
// - Runs one channel or two channels
// - Each channel has a 64-bit data path
// - Asymmetric mode: channel 0 addresses first
// - Interleaved mode alternates channels per line
// - Common rate is that of slowest DIMM
// - Accepts 256M, 512M, 1G, x8 and x16
// - Four banks, or eight for 1G
// - Up to 32 open rows per channel
// - Decodes at most 4 GB
// - Page sizes of 4, 8, 16 KB
// - Burst length is always eight
// - Data mask protects unwritten bytes
// - Refresh placed in idle gaps, or forced when 8 are owed
// - Throttle reads/writes on heat or limits
// - Activity is weighted sum of commands
// - Configuration comes from software registers
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defs.svh"
module ddc_top #(
	parameter int WIN_CYC = `DDC_WIN_CYC
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// AXI4-Lite register slave
	input wire logic i_axi_awvalid,
	output logic o_axi_awready,
	input wire logic [7:0] i_axi_awaddr,
	input wire logic i_axi_wvalid,
	output logic o_axi_wready,
	input wire logic [31:0] i_axi_wdata,
	input wire logic [3:0] i_axi_wstrb,
	output logic o_axi_bvalid,
	input wire logic i_axi_bready,
	output logic [1:0] o_axi_bresp,
	input wire logic i_axi_arvalid,
	output logic o_axi_arready,
	input wire logic [7:0] i_axi_araddr,
	output logic o_axi_rvalid,
	input wire logic i_axi_rready,
	output logic [31:0] o_axi_rdata,
	output logic [1:0] o_axi_rresp,
	// Request stream
	input wire logic i_req_valid,
	output logic o_req_ready,
	input wire ddc_pkg::ddc_req_t i_req,
	// Thermal sensor pin
	input wire logic i_therm_hot,
	// Memory side
	output ddc_pkg::ddc_cmd_t [1:0] o_cmd,
	output logic o_rate_667
);
	function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
		end
		return r;
	endfunction : wmask

	function automatic logic known(input logic [7:0] a);
		return a inside {`DDC_CTRL, `DDC_GEOM, `DDC_ASZ, `DDC_LIM, `DDC_WGT, `DDC_STAT,
			`DDC_ACTV};
	endfunction : known

	function automatic logic [4:0] ix(input ddc_pkg::ddc_loc_t l);
		return {l.rank, l.bank};
	endfunction : ix

	// Host address to channel, rank, bank, row, column
	function automatic ddc_pkg::ddc_loc_t dmap(input logic [31:0] a, input logic [31:0] g,
		input logic [1:0] m, input logic [31:0] asz);
		ddc_pkg::ddc_loc_t r;
		logic [31:0] l;
		logic [31:0] s;
		int cb;
		int bb;
		int rb;
		r = '0;
		l = a;
		case (ddc_pkg::ddc_mode_t'(m))
			ddc_pkg::DDC_ASYM: begin
				if (a >= asz) begin
					r.ch = 1'b1;
					l = a - asz;
				end
			end
			ddc_pkg::DDC_ILV: begin
				r.ch = a[`DDC_ILV_BIT];
				l = {1'b0, a[31:`DDC_ILV_BIT+1], a[`DDC_ILV_BIT-1:0]};
			end
			default: r.ch = 1'b0;
		endcase
		cb = `DDC_COL_MIN + int'(g[`DDC_F_PAGE]);
		bb = (g[`DDC_F_DENS] == `DDC_D1G) ? 3 : 2;
		rb = (g[`DDC_F_RANKS] == 2'h0) ? 0 : (g[`DDC_F_RANKS] == 2'h1) ? 1 : 2;
		r.beat = l[`DDC_BEAT_W+2:3];
		s = l >> 3;
		r.col = 11'(s & ((32'h1 << cb) - 32'h1)) & ~11'h7;
		s = s >> cb;
		r.bank = 3'(s & ((32'h1 << bb) - 32'h1));
		s = s >> bb;
		r.rank = 2'(s & ((32'h1 << rb) - 32'h1));
		r.row = 16'(s >> rb);
		return r;
	endfunction : dmap

	// Reset release
	logic [1:0] rff_q;
	logic rst_n_s;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) rff_q <= 2'h0;
		else rff_q <= {rff_q[0], 1'b1};
	end
	assign rst_n_s = rff_q[1];

	logic [31:0] ctrl_q;
	logic [31:0] geom_q;
	logic [31:0] asz_q;
	logic [31:0] lim_q;
	logic [31:0] wgt_q;
	logic [31:0] act_q;
	logic [3:0] pend_q;
	logic hot_q;
	logic thr;
	ddc_pkg::ddc_st_t st_q;
	logic [1:0] bcnt_q;
	logic [1:0] mode;
	assign mode = ctrl_q[`DDC_F_MODE];

	// AXI4-Lite write path
	logic aw_h_q;
	logic w_h_q;
	logic bv_q;
	logic [7:0] awa_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic [1:0] br_q;
	logic wdo;
	assign o_axi_awready = !aw_h_q && !bv_q;
	assign o_axi_wready = !w_h_q && !bv_q;
	assign o_axi_bvalid = bv_q;
	assign o_axi_bresp = br_q;
	assign wdo = aw_h_q && w_h_q && !bv_q;
	always_ff @(posedge i_core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			aw_h_q <= 1'b0;
			w_h_q <= 1'b0;
			bv_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			br_q <= `DDC_OKAY;
		end else begin
			if (i_axi_awvalid && o_axi_awready) begin
				aw_h_q <= 1'b1;
				awa_q <= i_axi_awaddr;
			end
			if (i_axi_wvalid && o_axi_wready) begin
				w_h_q <= 1'b1;
				wd_q <= i_axi_wdata;
				ws_q <= i_axi_wstrb;
			end
			if (wdo) begin
				aw_h_q <= 1'b0;
				w_h_q <= 1'b0;
				bv_q <= 1'b1;
				br_q <= known(awa_q) ? `DDC_OKAY : `DDC_SLVERR;
			end else if (bv_q && i_axi_bready) begin
				bv_q <= 1'b0;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge i_core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			ctrl_q <= `DDC_CTRL_RST;
			geom_q <= `DDC_GEOM_RST;
			asz_q <= 32'h0;
			lim_q <= `DDC_LIM_RST;
			wgt_q <= `DDC_WGT_RST;
		end else if (wdo) begin
			case (awa_q)
				`DDC_CTRL: ctrl_q <= wmask(ctrl_q, wd_q, ws_q);
				`DDC_GEOM: geom_q <= wmask(geom_q, wd_q, ws_q);
				`DDC_ASZ: asz_q <= wmask(asz_q, wd_q, ws_q);
				`DDC_LIM: lim_q <= wmask(lim_q, wd_q, ws_q);
				`DDC_WGT: wgt_q <= wmask(wgt_q, wd_q, ws_q);
				default: ;
			endcase
		end
	end

	// AXI4-Lite read path
	logic rv_q;
	logic [31:0] rd_q;
	logic [1:0] rr_q;
	logic [31:0] stat;
	logic gerr;
	assign gerr = geom_q[`DDC_F_DENS] == `DDC_BAD || geom_q[`DDC_F_PAGE] == 2'h3;
	assign stat = {23'h0, st_q == ddc_pkg::S_IDLE && bcnt_q == 2'h0, pend_q, gerr,
		o_rate_667, hot_q, thr};
	assign o_axi_arready = !rv_q;
	assign o_axi_rvalid = rv_q;
	assign o_axi_rdata = rd_q;
	assign o_axi_rresp = rr_q;
	always_ff @(posedge i_core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			rv_q <= 1'b0;
			rd_q <= 32'h0;
			rr_q <= `DDC_OKAY;
		end else if (i_axi_arvalid && o_axi_arready) begin
			rv_q <= 1'b1;
			rr_q <= known(i_axi_araddr) ? `DDC_OKAY : `DDC_SLVERR;
			case (i_axi_araddr)
				`DDC_CTRL: rd_q <= ctrl_q;
				`DDC_GEOM: rd_q <= geom_q;
				`DDC_ASZ: rd_q <= asz_q;
				`DDC_LIM: rd_q <= lim_q;
				`DDC_WGT: rd_q <= wgt_q;
				`DDC_STAT: rd_q <= stat;
				`DDC_ACTV: rd_q <= act_q;
				default: rd_q <= 32'h0;
			endcase
		end else if (rv_q && i_axi_rready) begin
			rv_q <= 1'b0;
		end
	end

	// Two-entry request buffer
	ddc_pkg::ddc_req_t buf_q [2];
	ddc_pkg::ddc_req_t head;
	logic bwp_q;
	logic brp_q;
	logic push;
	logic pop;
	logic hv;
	assign o_req_ready = bcnt_q != 2'h2;
	assign push = i_req_valid && o_req_ready;
	assign hv = bcnt_q != 2'h0;
	assign head = buf_q[brp_q];
	always_ff @(posedge i_core_clk) begin
		if (push) buf_q[bwp_q] <= i_req;
	end
	always_ff @(posedge i_core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			bcnt_q <= 2'h0;
			bwp_q <= 1'b0;
			brp_q <= 1'b0;
		end else begin
			if (push) bwp_q <= !bwp_q;
			if (pop) brp_q <= !brp_q;
			bcnt_q <= bcnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	// Thermal pin sync and DIMM rate
	logic [2:0] hs_q;
	always_ff @(posedge i_core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			hs_q <= 3'h0;
			hot_q <= 1'b0;
			o_rate_667 <= 1'b0;
		end else begin
			hs_q <= {hs_q[1:0], i_therm_hot};
			if (hs_q[1] == hs_q[2]) hot_q <= hs_q[2];
			// Any slow or absent-capability DIMM pulls all channels down
			o_rate_667 <= geom_q[`DDC_F_PRES] != 4'h0 &&
				(geom_q[`DDC_F_PRES] & ~geom_q[`DDC_F_FAST]) == 4'h0;
		end
	end

	// Refresh interval and backlog
	logic [$clog2(`DDC_REF_CYC)-1:0] rtim_q;
	logic rtick;
	logic ref_done;
	logic rforce;
	assign rtick = rtim_q == ($clog2(`DDC_REF_CYC))'(`DDC_REF_CYC - 1);
	assign rforce = pend_q == `DDC_REF_POST;
	always_ff @(posedge i_core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			rtim_q <= '0;
			pend_q <= 4'h0;
		end else begin
			rtim_q <= rtick ? '0 : rtim_q + 1'b1;
			if (rtick && !ref_done && !rforce) pend_q <= pend_q + 4'h1;
			else if (ref_done && !rtick) pend_q <= pend_q - 4'h1;
		end
	end

	// Weighted activity window and throttling
	logic [$clog2(WIN_CYC)-1:0] win_q;
	logic wend;
	logic lhit_q;
	logic [7:0] wnow;
	logic blk;
	ddc_pkg::ddc_req_t cur_q;
	assign wend = win_q == ($clog2(WIN_CYC))'(WIN_CYC - 1);
	always_comb begin
		case (st_q)
			ddc_pkg::S_ACT: wnow = wgt_q[`DDC_W_ACT];
			ddc_pkg::S_RW: wnow = cur_q.wr ? wgt_q[`DDC_W_WR] : wgt_q[`DDC_W_RD];
			ddc_pkg::S_PRE, ddc_pkg::S_RFP: wnow = wgt_q[`DDC_W_PRE];
			default: wnow = 8'h00;
		endcase
	end
	always_ff @(posedge i_core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			win_q <= '0;
			act_q <= 32'h0;
			lhit_q <= 1'b0;
		end else begin
			win_q <= wend ? '0 : win_q + 1'b1;
			act_q <= (wend ? 32'h0 : act_q) + {24'h0, wnow};
			// A hit in the closing cycle still counts: set wins over the window clear
			lhit_q <= (lhit_q && !wend) || (ctrl_q[`DDC_F_LIM] && act_q >= lim_q);
		end
	end
	assign thr = lhit_q || (ctrl_q[`DDC_F_THERM] && hot_q);
	assign blk = thr && (head.wr ? ctrl_q[`DDC_F_THR_WR] : ctrl_q[`DDC_F_THR_RD]);

	// Command sequencer with open-row table
	ddc_pkg::ddc_loc_t hloc;
	ddc_pkg::ddc_loc_t loc_q;
	logic [1:0] rk_q;
	logic [31:0] open_q [2];
	logic [15:0] row_q [2][32];
	logic refgo;
	logic ch1;
	logic [1:0] last;
	assign hloc = dmap(head.addr, geom_q, mode, asz_q);
	assign ch1 = mode != ddc_pkg::DDC_SINGLE;
	assign last = geom_q[`DDC_F_RANKS];
	// Refresh only steals cycles that have no runnable request, unless backlog is full
	assign refgo = pend_q != 4'h0 && (rforce || !hv || blk);
	assign pop = st_q == ddc_pkg::S_IDLE && !refgo && hv && !blk;
	assign ref_done = st_q == ddc_pkg::S_RFR && rk_q == last;
	always_ff @(posedge i_core_clk) begin
		if (pop) begin
			loc_q <= hloc;
			cur_q <= head;
		end
		if (st_q == ddc_pkg::S_ACT) row_q[loc_q.ch][ix(loc_q)] <= loc_q.row;
	end
	always_ff @(posedge i_core_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_q <= ddc_pkg::S_IDLE;
			rk_q <= 2'h0;
			open_q[0] <= 32'h0;
			open_q[1] <= 32'h0;
			o_cmd <= '0;
		end else begin
			o_cmd <= '0;
			case (st_q)
				ddc_pkg::S_IDLE: begin
					if (refgo) begin
						st_q <= ddc_pkg::S_RFP;
						rk_q <= 2'h0;
					end else if (pop) begin
						if (!open_q[hloc.ch][ix(hloc)]) st_q <= ddc_pkg::S_ACT;
						else if (row_q[hloc.ch][ix(hloc)] == hloc.row) st_q <= ddc_pkg::S_RW;
						else st_q <= ddc_pkg::S_PRE;
					end
				end
				ddc_pkg::S_PRE: begin
					o_cmd[loc_q.ch].op <= ddc_pkg::DDC_PRE;
					o_cmd[loc_q.ch].rank <= loc_q.rank;
					o_cmd[loc_q.ch].bank <= loc_q.bank;
					open_q[loc_q.ch][ix(loc_q)] <= 1'b0;
					st_q <= ddc_pkg::S_ACT;
				end
				ddc_pkg::S_ACT: begin
					o_cmd[loc_q.ch].op <= ddc_pkg::DDC_ACT;
					o_cmd[loc_q.ch].rank <= loc_q.rank;
					o_cmd[loc_q.ch].bank <= loc_q.bank;
					o_cmd[loc_q.ch].row <= loc_q.row;
					open_q[loc_q.ch][ix(loc_q)] <= 1'b1;
					st_q <= ddc_pkg::S_RW;
				end
				ddc_pkg::S_RW: begin
					o_cmd[loc_q.ch].op <= cur_q.wr ? ddc_pkg::DDC_WR : ddc_pkg::DDC_RD;
					o_cmd[loc_q.ch].rank <= loc_q.rank;
					o_cmd[loc_q.ch].bank <= loc_q.bank;
					// Row rides along so the far side can confirm the hit decision
					o_cmd[loc_q.ch].row <= loc_q.row;
					o_cmd[loc_q.ch].col <= loc_q.col;
					o_cmd[loc_q.ch].blen <= `DDC_BL;
					o_cmd[loc_q.ch].beat <= loc_q.beat;
					o_cmd[loc_q.ch].wdata <= cur_q.wdata;
					// Only the addressed beat's enabled bytes are left unmasked
					if (cur_q.wr) o_cmd[loc_q.ch].byte_write_mask <=
						~({56'h0, cur_q.be} << {loc_q.beat, 3'h0});
					st_q <= ddc_pkg::S_IDLE;
				end
				ddc_pkg::S_RFP, ddc_pkg::S_RFR: begin
					for (int c = 0; c < 2; c++) begin
						if (c == 0 || ch1) begin
							o_cmd[c].op <= st_q == ddc_pkg::S_RFP ? ddc_pkg::DDC_PRE :
								ddc_pkg::DDC_REF;
							o_cmd[c].rank <= rk_q;
							o_cmd[c].all <= 1'b1;
							if (st_q == ddc_pkg::S_RFP)
								open_q[c] <= open_q[c] & ~(32'hff << {rk_q, 3'h0});
						end
					end
					if (st_q == ddc_pkg::S_RFP) st_q <= ddc_pkg::S_RFR;
					else if (rk_q == last) st_q <= ddc_pkg::S_IDLE;
					else begin
						rk_q <= rk_q + 2'h1;
						st_q <= ddc_pkg::S_RFP;
					end
				end
				default: st_q <= ddc_pkg::S_IDLE;
			endcase
		end
	end

	a_burst_eight: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		o_cmd[0].op inside {ddc_pkg::DDC_RD, ddc_pkg::DDC_WR} |-> o_cmd[0].blen == `DDC_BL)
		else $error("burst length not eight");
	a_ilv_chan: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		pop && mode == ddc_pkg::DDC_ILV |=> loc_q.ch == $past(head.addr[`DDC_ILV_BIT]))
		else $error("interleave channel not address bit 6");
	a_asym_chan: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		pop && mode == ddc_pkg::DDC_ASYM |=> loc_q.ch == ($past(head.addr) >= $past(asz_q)))
		else $error("asymmetric channel wrong");
	a_mask_part: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		o_cmd[0].op == ddc_pkg::DDC_WR |-> $countones(~o_cmd[0].byte_write_mask) <= 8)
		else $error("write leaves other beats unmasked");
	a_ref_force: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		st_q == ddc_pkg::S_IDLE && rforce |=> st_q == ddc_pkg::S_RFP ##1 st_q == ddc_pkg::S_RFR)
		else $error("forced refresh not started");
	a_ref_cap: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		pend_q <= `DDC_REF_POST)
		else $error("refresh backlog overflow");
	a_thr_block: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		thr && ctrl_q[`DDC_F_THR_RD] && ctrl_q[`DDC_F_THR_WR] |-> !pop)
		else $error("request taken while throttled");
	a_act_sum: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		st_q == ddc_pkg::S_ACT && !wend |=>
			act_q == $past(act_q) + {24'h0, $past(wgt_q[`DDC_W_ACT])})
		else $error("activate weight not added");
	a_bank_four: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		o_cmd[0].op == ddc_pkg::DDC_ACT && geom_q[`DDC_F_DENS] != `DDC_D1G
			&& $stable(geom_q) |-> !o_cmd[0].bank[2])
		else $error("bank above three on four-bank part");
	a_single_ch: assert property (@(posedge i_core_clk) disable iff (!rst_n_s)
		(mode == ddc_pkg::DDC_SINGLE)[*2] |-> o_cmd[1].op == ddc_pkg::DDC_NOP)
		else $error("second channel used in single mode");
endmodule : ddc_top
`default_nettype wire

/* File: test/ddc_dimm_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ddc_dimm_model (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Command stream of one channel
	input wire ddc_pkg::ddc_cmd_t i_cmd,
	input wire logic i_eight_banks,
	// Protocol faults and refresh count
	output int o_errs,
	output int o_refs
);
	logic open_q [0:3][0:7];
	logic [15:0] row_q [0:3][0:7];
	// Unbuffered part: each command acts in its own cycle, no register stage
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int r = 0; r < 4; r++) begin
				for (int b = 0; b < 8; b++) begin
					open_q[r][b] <= 1'b0;
					row_q[r][b] <= 16'h0000;
				end
			end
			o_errs <= 0;
			o_refs <= 0;
		end else begin
			case (i_cmd.op)
			ddc_pkg::DDC_ACT: begin
				if (open_q[i_cmd.rank][i_cmd.bank] || (!i_eight_banks && i_cmd.bank[2])) begin
					o_errs <= o_errs + 1;
				end
				open_q[i_cmd.rank][i_cmd.bank] <= 1'b1;
				row_q[i_cmd.rank][i_cmd.bank] <= i_cmd.row;
			end
			ddc_pkg::DDC_RD, ddc_pkg::DDC_WR: begin
				if (!open_q[i_cmd.rank][i_cmd.bank] || row_q[i_cmd.rank][i_cmd.bank] != i_cmd.row
					|| i_cmd.blen != 4'h8 || i_cmd.col[2:0] != 3'h0) begin
					o_errs <= o_errs + 1;
				end
			end
			ddc_pkg::DDC_PRE: begin
				for (int b = 0; b < 8; b++) begin
					if (i_cmd.all || i_cmd.bank == b[2:0]) begin
						open_q[i_cmd.rank][b] <= 1'b0;
					end
				end
			end
			ddc_pkg::DDC_REF: begin
				// A refresh into an open bank would corrupt that row
				for (int b = 0; b < 8; b++) begin
					if (open_q[i_cmd.rank][b]) begin
						o_errs <= o_errs + 1;
					end
				end
				o_refs <= o_refs + 1;
			end
			default: ;
			endcase
		end
	end
endmodule : ddc_dimm_model
`default_nettype wire

/* File: test/dual_channel_ddr2_controller_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ddc_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module dual_channel_ddr2_controller_tb_top;
	typedef struct packed {logic ch; logic wr; logic [2:0] beat; logic [63:0] data;
		logic [63:0] mask;} ddc_exp_t;
	localparam logic [31:0] ASZ = 32'h0010_0000;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, req_valid, hot, big;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	wire logic awready, wready, bvalid, arready, rvalid, req_ready, rate_667;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	ddc_pkg::ddc_req_t req;
	ddc_pkg::ddc_cmd_t [1:0] cmd;
	int fails = 0, n_checks = 0, cyc = 0, n_ref = 0, r0 = 0, errs[2], refs[2];
	integer seed = 32'h8239570b;
	ddc_exp_t exq[$];
	ddc_top #(.WIN_CYC(16)) uut (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_awaddr(awaddr),
		.i_axi_wvalid(wvalid), .o_axi_wready(wready), .i_axi_wdata(wdata), .i_axi_wstrb(wstrb),
		.o_axi_bvalid(bvalid), .i_axi_bready(bready), .o_axi_bresp(bresp),
		.i_axi_arvalid(arvalid), .o_axi_arready(arready), .i_axi_araddr(araddr),
		.o_axi_rvalid(rvalid), .i_axi_rready(rready), .o_axi_rdata(rdata), .o_axi_rresp(rresp),
		.i_req_valid(req_valid), .o_req_ready(req_ready), .i_req(req),
		.i_therm_hot(hot), .o_cmd(cmd), .o_rate_667(rate_667));
	for (genvar c = 0; c < 2; c++) begin : g_dimm
		ddc_dimm_model dimm (.i_core_clk(clk), .i_rst_n(rst_n), .i_cmd(cmd[c]),
			.i_eight_banks(big), .o_errs(errs[c]), .o_refs(refs[c]));
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic stop_test();
		$display("Checks %0d, errors %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	// Model side: every burst pops the oldest expected request, in order
	always @(posedge clk) begin
		ddc_exp_t e;
		for (int c = 0; c < 2; c++) begin
			if (c == 0 && cmd[c].op == ddc_pkg::DDC_REF) n_ref++;
			if (cmd[c].op == ddc_pkg::DDC_RD || cmd[c].op == ddc_pkg::DDC_WR) begin
				if (exq.size() == 0) begin
					fails++;
					$display("Error burst expected none seen %h", cmd[c].op);
				end else begin
					e = exq.pop_front();
					`CHK("channel", e.ch, c[0])
					`CHK("write", e.wr, cmd[c].op == ddc_pkg::DDC_WR)
					`CHK("blen", 4'h8, cmd[c].blen)
					`CHK("beat", e.beat, cmd[c].beat)
					`CHK("mask", e.mask, cmd[c].byte_write_mask)
					if (e.wr) `CHK("wdata", e.data, cmd[c].wdata)
				end
			end
		end
	end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		`CHK("bresp", er, bresp)
		bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m,
		input logic [1:0] er);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		`CHK("rdata", ed & m, rdata & m)
		`CHK("rresp", er, rresp)
		rready <= 1'b0;
	endtask : axi_rd
	// Kind 0 read, 1 write, 2 random; the mode and address decide the channel
	task automatic send(input logic [31:0] a, input logic [1:0] md, input logic [1:0] kind);
		ddc_exp_t e;
		logic [31:0] r, loc;
		r = $random(seed);
		e.wr = kind[1] ? r[0] : kind[0];
		loc = (md == ddc_pkg::DDC_ASYM && a >= ASZ) ? a - ASZ : a;
		e.ch = (md == ddc_pkg::DDC_ASYM) ? (a >= ASZ) : (md == ddc_pkg::DDC_ILV) ? a[6] : 1'b0;
		e.beat = loc[5:3];
		e.data = {$random(seed), $random(seed)};
		e.mask = e.wr ? 64'hffff_ffff_ffff_ffff : 64'h0;
		if (e.wr) e.mask[e.beat*8 +: 8] = ~r[15:8];
		exq.push_back(e);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{addr: a, wr: e.wr, wdata: e.data, be: r[15:8]};
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
	endtask : send
	task automatic drain();
		while (exq.size() != 0) @(posedge clk);
	endtask : drain
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, req_valid, hot, big} = 8'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		wstrb = 4'hf;
		req = '0;
		rst_n = 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		axi_rd(`DDC_LIM, 32'hffff_ffff, 32'hffff_ffff, `DDC_OKAY);
		axi_rd(`DDC_WGT, 32'h0101_0101, 32'hffff_ffff, `DDC_OKAY);
		axi_rd(`DDC_CTRL, 32'h0, 32'hffff_ffff, `DDC_OKAY);
		axi_rd(8'h1c, 32'h0, 32'hffff_ffff, `DDC_SLVERR);
		axi_wr(8'h1c, 32'h1, `DDC_SLVERR);
		axi_wr(`DDC_GEOM, 32'h0000_3300, `DDC_OKAY);
		repeat (2) @(posedge clk);
		`CHK("rate", 1'b1, rate_667)
		axi_wr(`DDC_GEOM, 32'h0000_1300, `DDC_OKAY);
		repeat (2) @(posedge clk);
		`CHK("rate", 1'b0, rate_667)
		axi_wr(`DDC_GEOM, 32'h0000_1303, `DDC_OKAY);
		axi_rd(`DDC_STAT, 32'h8, 32'h8, `DDC_OKAY);
		axi_wr(`DDC_ASZ, ASZ, `DDC_OKAY);
		for (int m = 0; m < 3; m++) begin
			big <= (m == 2);
			axi_wr(`DDC_GEOM, (m == 2) ? 32'h0000_1302 : 32'h0000_1300, `DDC_OKAY);
			axi_wr(`DDC_CTRL, m, `DDC_OKAY);
			for (int k = 0; k < 6; k++) begin
				send((k < 2) ? ASZ - 8 + 8 * k : $random(seed) & 32'h001f_fff8, m[1:0], 2'h2);
			end
			drain();
		end
		axi_wr(`DDC_CTRL, 32'h18, `DDC_OKAY);
		hot <= 1'b1;
		repeat (6) @(posedge clk);
		axi_rd(`DDC_STAT, 32'h3, 32'h3, `DDC_OKAY);
		send(32'h40, 2'h0, 2'h0);
		send(32'h80, 2'h0, 2'h1);
		repeat (40) @(posedge clk);
		`CHK("held", 1, exq.size())
		hot <= 1'b0;
		drain();
		// Zero limit trips at once and every cycle; both kinds held until CTRL is written back to zero
		axi_wr(`DDC_LIM, 32'h0, `DDC_OKAY);
		axi_wr(`DDC_CTRL, 32'h2c, `DDC_OKAY);
		axi_rd(`DDC_STAT, 32'h1, 32'h1, `DDC_OKAY);
		send(32'h100, 2'h0, 2'h0);
		repeat (40) @(posedge clk);
		`CHK("limit", 1, exq.size())
		axi_wr(`DDC_CTRL, 32'h0, `DDC_OKAY);
		drain();
		n_ref = 0;
		r0 = refs[0];
		repeat (900) @(posedge clk);
		`CHK("refresh", 1'b1, n_ref >= 2)
		`CHK("model refresh", 1'b1, refs[0] - r0 >= 2)
		`CHK("proto0", 0, errs[0])
		`CHK("proto1", 0, errs[1])
		stop_test();
	end
endmodule : dual_channel_ddr2_controller_tb_top
`default_nettype wire
